//--- rtl/pwm_timer_regs.svh
// Behaviour
// RULE1: PWM period runs from autoreload value to 4095; frequency is clock over 4096 minus it.
// RULE2: Second-counter enable clear selects single-counter mode, set selects dual-counter mode.
// RULE3: In dual mode outputs two and three use the second counter and its reload.
// RULE4: Duty writes go to preload; overflow copies them when the matching transfer bit is set.
// RULE5: After reset each counter counts upward from zero; counter two stays at zero until second-counter enable is set.
// RULE6: Overflow drives outputs high; counter equal to active duty drives that output low.
// RULE7: Software keeps duty above autoreload; reload at most 4094 with duty 4095.
// RULE8: Each output has polarity invert, applied at overflow when the transfer bit is set.
// RULE9: Each output is driven by the timer only while its output-enable bit is set.
// RULE10: Dead-time enable inserts a gap between outputs zero and one of count clocks.
// RULE11: Dead-time register writes are buffered and applied after the next overflow.
// RULE12: Dead-time enable with zero count holds the outputs at their reset state.
// RULE13: Output zero falls at match, rises at period end plus gap; output one mirrors.
// RULE14: Break source is pin or comparator by select bit; acts only when function enabled.
// RULE15: Break input at the selected active level sets the break-active flag.
// RULE16: Software writing the break-active flag to one also activates break.
// RULE17: Single mode first break enable gates all; dual mode second gates outputs two, three.
// RULE18: Enabled break forces the break pattern onto enabled outputs after the inverter.
// RULE19: Enabled break clears counters, reloads and duty registers and stops counting.
// RULE20: Clearing the break-active flag returns the outputs to the timer logic.
// RULE21: Counter equal to active duty sets the compare flag and irq if enabled.
// RULE22: Single mode compares counter one to all; dual mode splits channels by counter.
// RULE23: A zero active duty value never sets a compare flag.
// RULE24: At 4095 a counter overflows and reloads its autoreload value next clock.
`ifndef PWM_TIMER_REGS_SVH
`define PWM_TIMER_REGS_SVH
`define OFS_CTRL      12'h000
`define OFS_RELOAD1   12'h004
`define OFS_RELOAD2   12'h008
`define OFS_DUTY0     12'h00C
`define OFS_OUTCTRL   12'h01C
`define OFS_DEADTIME  12'h020
`define OFS_BREAK     12'h024
`define OFS_STATUS    12'h028
`define OFS_CNT1      12'h02C
`define OFS_CNT2      12'h030
`define CNT_TOP       12'hFFF
`define CNT_ZERO      12'h000
`define DUTY_RANGE    3'h4
`endif

//--- rtl/pwm_timer_pkg.sv
package pwm_timer_pkg;
   typedef struct packed {
      logic       paddr_ok;
      logic [9:0] idx;
   } unused_t;
   typedef struct packed {
      logic       cmp_irq_enable;
      logic [1:0] transfer_enable;
      logic       second_counter_enable;
   } ctrl_t;
   typedef struct packed {
      logic       first_break_enable;
      logic       second_break_enable;
      logic [3:0] pattern;
      logic       break_level_select;
      logic       break_source_select;
      logic       break_function_enable;
   } brk_t;
   typedef struct packed {
      logic       dead_time_enable;
      logic [6:0] dead_time_count;
   } dt_t;
   typedef struct packed {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;
endpackage

//--- rtl/pwm_timer.sv
`include "pwm_timer_regs.svh"
module pwm_timer (
   // Clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire pwm_timer_pkg::apb_req_t apb_req,
   output pwm_timer_pkg::apb_rsp_t      apb_rsp,
   // Break sources, asynchronous
   input  wire logic                   break_pin,
   input  wire logic                   comparator_out,
   // Outputs to power stage
   output logic [3:0]                  modulated_output,
   output logic [3:0]                  output_drive_en,
   output logic                        compare_irq
);
   import pwm_timer_pkg::*;

   function automatic logic [11:0] cnt_next(input logic [11:0] c, input logic [11:0] r);
      cnt_next = (c == `CNT_TOP) ? r : c + 12'h001;
   endfunction

   // Registers
   ctrl_t        ctrl_q, ctrl_d;
   brk_t         brk_q, brk_d;
   dt_t          dt_pre_q, dt_pre_d, dt_act_q, dt_act_d;
   logic [3:0]   output_enable_bits_q, output_enable_bits_d;
   logic [3:0]   pol_pre_q, pol_pre_d, pol_act_q, pol_act_d;
   logic [11:0]  reload_q [2], reload_d [2];
   logic [11:0]  pre_q [4], pre_d [4], act_q [4], act_d [4];
   logic [11:0]  first_up_counter_q, first_up_counter_d;
   logic [11:0]  second_up_counter_q, second_up_counter_d;
   logic [3:0]   wave_q, wave_d, compare_flag_q, compare_flag_d;
   logic [6:0]   gap_q [2], gap_d [2];
   logic [3:0]   out_q, out_d, oen_q, oen_d;
   logic         irq_q, irq_d, break_active_q, break_active_d;
   logic         bpin_s1_q, bpin_s2_q, bcmp_s1_q, bcmp_s2_q;
   apb_rsp_t     rsp_q, rsp_d;

   // Derived
   logic         dual, ovf1, ovf2, trig, brk1, brk2, wr, rd;
   logic [3:0]   chan_ovf, chan_match, chan_brk, wave_pol;
   logic [11:0]  chan_cnt [4];

   always_comb begin
      dual = ctrl_q.second_counter_enable;                       // see RULE2
      ovf1 = first_up_counter_q == `CNT_TOP;                     // see RULE24
      ovf2 = second_up_counter_q == `CNT_TOP;
      // Source picked, then the level compared
      trig = (brk_q.break_source_select ? bcmp_s2_q : bpin_s2_q)
             == brk_q.break_level_select;                        // see RULE14
      // Flag alone does nothing until the function is enabled
      brk1 = break_active_q && brk_q.break_function_enable
             && brk_q.first_break_enable;                        // see RULE14
      brk2 = break_active_q && brk_q.break_function_enable
             && (dual ? brk_q.second_break_enable
                      : brk_q.first_break_enable);               // see RULE17
      chan_brk = {brk2, brk2, brk1, brk1};
      for (int i = 0; i < 4; i++) begin
         // Dual mode moves channels two and three to counter two
         chan_cnt[i] = (dual && i >= 2) ? second_up_counter_q : first_up_counter_q; // see RULE22
         chan_ovf[i] = (dual && i >= 2) ? ovf2 : ovf1;            // see RULE3
         chan_match[i] = (chan_cnt[i] == act_q[i]) && (act_q[i] != `CNT_ZERO); // see RULE23
      end
      wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
      rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   end

   // Synchronisers for the break sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bpin_s1_q <= 1'b0;
         bpin_s2_q <= 1'b0;
         bcmp_s1_q <= 1'b0;
         bcmp_s2_q <= 1'b0;
      end else begin
         bpin_s1_q <= break_pin;
         bpin_s2_q <= bpin_s1_q;
         bcmp_s1_q <= comparator_out;
         bcmp_s2_q <= bcmp_s1_q;
      end
   end

   // Register file and break flag
   always_comb begin
      ctrl_d = ctrl_q;
      brk_d = brk_q;
      dt_pre_d = dt_pre_q;
      output_enable_bits_d = output_enable_bits_q;
      pol_pre_d = pol_pre_q;
      reload_d = reload_q;
      pre_d = pre_q;
      break_active_d = break_active_q;
      if (wr) begin
         unique case (apb_req.paddr)
            `OFS_CTRL:     ctrl_d = apb_req.pwdata[3:0];
            `OFS_RELOAD1:  reload_d[0] = apb_req.pwdata[11:0];
            `OFS_RELOAD2:  reload_d[1] = apb_req.pwdata[11:0];
            `OFS_OUTCTRL: begin
               output_enable_bits_d = apb_req.pwdata[3:0];
               pol_pre_d = apb_req.pwdata[7:4];
            end
            `OFS_DEADTIME: dt_pre_d = apb_req.pwdata[7:0];       // see RULE11
            `OFS_BREAK: begin
               brk_d = apb_req.pwdata[8:0];
               break_active_d = apb_req.pwdata[9];               // see RULE16 RULE20
            end
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (apb_req.paddr == `OFS_DUTY0 + 12'(i * 4)) begin
                     pre_d[i] = apb_req.pwdata[11:0];            // see RULE4
                  end
               end
            end
         endcase
      end
      // Hardware set beats the software clear
      if (brk_q.break_function_enable && trig) begin
         break_active_d = 1'b1;                                  // see RULE15
      end
      if (brk1 || brk2) begin
         reload_d[0] = `CNT_ZERO;                                // see RULE19
         reload_d[1] = `CNT_ZERO;
         for (int i = 0; i < 4; i++) begin
            pre_d[i] = `CNT_ZERO;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         ctrl_q.transfer_enable <= 2'b11;
         brk_q <= '0;
         dt_pre_q <= '0;
         output_enable_bits_q <= '0;
         pol_pre_q <= '0;
         reload_q <= '{default: `CNT_ZERO};
         pre_q <= '{default: `CNT_ZERO};
         break_active_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         brk_q <= brk_d;
         dt_pre_q <= dt_pre_d;
         output_enable_bits_q <= output_enable_bits_d;
         pol_pre_q <= pol_pre_d;
         reload_q <= reload_d;
         pre_q <= pre_d;
         break_active_q <= break_active_d;
      end
   end

   // Counters, waveforms and compare
   always_comb begin
      first_up_counter_d = cnt_next(first_up_counter_q, reload_q[0]); // see RULE1 RULE24
      second_up_counter_d = dual ? cnt_next(second_up_counter_q, reload_q[1]) : `CNT_ZERO;
      if (brk1) begin
         first_up_counter_d = `CNT_ZERO;                         // see RULE19
      end
      if (brk2 && dual) begin
         second_up_counter_d = `CNT_ZERO;
      end
      act_d = act_q;
      pol_act_d = pol_act_q;
      wave_d = wave_q;
      dt_act_d = dt_act_q;
      gap_d = gap_q;
      compare_flag_d = compare_flag_q;
      if (rd && apb_req.paddr == `OFS_STATUS) begin
         compare_flag_d = '0;
      end
      if (ovf1) begin
         dt_act_d = dt_pre_q;                                    // see RULE11
      end
      for (int i = 0; i < 4; i++) begin
         if (chan_ovf[i] && !chan_brk[i]) begin
            wave_d[i] = 1'b1;                                    // see RULE6
            if (ctrl_q.transfer_enable[(dual && i >= 2) ? 1 : 0]) begin
               act_d[i] = pre_q[i];                              // see RULE4
               pol_act_d[i] = pol_pre_q[i];                      // see RULE8
            end
         end else if (chan_match[i]) begin
            wave_d[i] = 1'b0;                                    // see RULE6
         end
         if (chan_match[i] && !chan_brk[i]) begin
            compare_flag_d[i] = 1'b1;                            // see RULE21
         end
         if (chan_brk[i]) begin
            act_d[i] = `CNT_ZERO;                                // see RULE19
         end
      end
      // Gap counters: 0 restarts at period end, 1 at channel zero match
      for (int k = 0; k < 2; k++) begin
         if ((k == 0 ? ovf1 : chan_match[0]) && !brk1) begin
            gap_d[k] = dt_act_q.dead_time_count;
         end else if (gap_q[k] != 7'h00) begin
            gap_d[k] = gap_q[k] - 7'h01;
         end
      end
      irq_d = |(compare_flag_q & {4{ctrl_q.cmp_irq_enable}});    // see RULE21
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_up_counter_q <= `CNT_ZERO;                        // see RULE5
         second_up_counter_q <= `CNT_ZERO;
         act_q <= '{default: `CNT_ZERO};
         pol_act_q <= '0;
         wave_q <= '0;
         dt_act_q <= '0;
         gap_q <= '{default: 7'h00};
         compare_flag_q <= '0;
         irq_q <= 1'b0;
      end else begin
         first_up_counter_q <= first_up_counter_d;
         second_up_counter_q <= second_up_counter_d;
         act_q <= act_d;
         pol_act_q <= pol_act_d;
         wave_q <= wave_d;
         dt_act_q <= dt_act_d;
         gap_q <= gap_d;
         compare_flag_q <= compare_flag_d;
         irq_q <= irq_d;
      end
   end

   // Output stage, registered
   always_comb begin
      wave_pol = wave_q;
      if (dt_act_q.dead_time_enable) begin
         // Both halves held off while a gap counter runs
         wave_pol[0] = wave_q[0] && (gap_q[0] == 7'h00);         // see RULE10 RULE13
         wave_pol[1] = !wave_q[0] && (gap_q[1] == 7'h00);        // see RULE13
      end
      wave_pol = wave_pol ^ pol_act_q;                           // see RULE8
      // Zero count holds the pair at reset level, inverter included
      if (dt_act_q.dead_time_enable && dt_act_q.dead_time_count == 7'h00) begin
         wave_pol[1:0] = 2'b00;                                  // see RULE12
      end
      out_d = '0;
      oen_d = 4'hF;
      for (int i = 0; i < 4; i++) begin
         if (output_enable_bits_q[i]) begin
            oen_d[i] = 1'b0;                                     // see RULE9
            out_d[i] = chan_brk[i] ? brk_q.pattern[i] : wave_pol[i]; // see RULE18
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= '0;
         oen_q <= 4'hF;
      end else begin
         out_q <= out_d;
         oen_q <= oen_d;
      end
   end

   // APB read data, answered in the access cycle
   always_comb begin
      rsp_d = '0;
      rsp_d.pready = 1'b1;
      if (apb_req.psel && !apb_req.penable) begin
         unique case (apb_req.paddr)
            `OFS_CTRL:     rsp_d.prdata[3:0] = ctrl_q;
            `OFS_RELOAD1:  rsp_d.prdata[11:0] = reload_q[0];
            `OFS_RELOAD2:  rsp_d.prdata[11:0] = reload_q[1];
            `OFS_OUTCTRL:  rsp_d.prdata[7:0] = {pol_pre_q, output_enable_bits_q};
            `OFS_DEADTIME: rsp_d.prdata[7:0] = dt_pre_q;
            `OFS_BREAK:    rsp_d.prdata[9:0] = {break_active_q, brk_q};
            `OFS_STATUS:   rsp_d.prdata[3:0] = compare_flag_q;
            `OFS_CNT1:     rsp_d.prdata[11:0] = first_up_counter_q;
            `OFS_CNT2:     rsp_d.prdata[11:0] = second_up_counter_q;
            default: begin
               rsp_d.pslverr = 1'b1;
               for (int i = 0; i < 4; i++) begin
                  if (apb_req.paddr == `OFS_DUTY0 + 12'(i * 4)) begin
                     rsp_d.prdata[11:0] = pre_q[i];
                     rsp_d.pslverr = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

   assign apb_rsp = '{prdata: rsp_q.prdata, pready: 1'b1, pslverr: rsp_q.pslverr};
   assign modulated_output = out_q;
   assign output_drive_en = oen_q;
   assign compare_irq = irq_q;
endmodule

//--- tb/pwm_timer_props.sv
module pwm_timer_props (
   // Clock and reset
   input wire logic                    pclk,
   input wire logic                    presetn,
   // Bus
   input wire pwm_timer_pkg::apb_req_t apb_req,
   input wire pwm_timer_pkg::apb_rsp_t apb_rsp,
   // Outputs
   input wire logic [3:0]              modulated_output,
   input wire logic [3:0]              output_drive_en,
   input wire logic                    compare_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_timer_pkg::*;
   logic        wr;
   logic        rs;
   logic [11:0] a;
   logic [31:0] d;
   logic [31:0] q;
   logic [3:0]  ctrl_q;
   logic [3:0]  pat_q;
   logic [7:0]  oc_q;
   logic        brk_q;
   logic        duty_q;
   assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rs = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
   assign a = apb_req.paddr;
   assign d = apb_req.pwdata;
   assign q = apb_rsp.prdata;
   // Shadow of what software wrote; hardware-set break is not tracked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 4'h6;
         pat_q <= 4'h0;
         oc_q <= 8'h00;
         brk_q <= 1'b0;
         duty_q <= 1'b0;
      end else if (wr) begin
         case (a)
            12'h000: ctrl_q <= d[3:0];
            12'h01C: oc_q <= d[7:0];
            12'h024: begin
               brk_q <= d[9] & d[8] & d[0];
               pat_q <= d[6:3];
            end
            12'h00C, 12'h010, 12'h014, 12'h018: duty_q <= 1'b1;
            default: ;
         endcase
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_off_low;
      (modulated_output & output_drive_en) == 4'h0;
   endproperty
   a_off_low: assert property (p_off_low) else $error("disabled output high");
   property p_oe_follow;
      wr && a == 12'h01C |-> ##2 output_drive_en == ~oc_q[3:0];
   endproperty
   a_oe_follow: assert property (p_oe_follow) else $error("enable mismatch");
   property p_oc_read;
      rs && a == 12'h01C |=> q == {24'h000000, oc_q};
   endproperty
   a_oc_read: assert property (p_oc_read) else $error("outctrl read");
   property p_ctrl_read;
      rs && a == 12'h000 |=> q == {28'h0000000, ctrl_q};
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read");
   property p_brk_pat;
      wr && a == 12'h024 && d[9] && d[8] && d[0] && !ctrl_q[0]
         |-> ##4 modulated_output == (pat_q & ~output_drive_en);
   endproperty
   a_brk_pat: assert property (p_brk_pat) else $error("break pattern");
   property p_brk_clr;
      rs && (a == 12'h004 || a == 12'h02C) && brk_q && $past(brk_q, 4) |=> q == 32'h0;
   endproperty
   a_brk_clr: assert property (p_brk_clr) else $error("not cleared in break");
   property p_irq_gate;
      !ctrl_q[3] && !$past(ctrl_q[3]) && !$past(ctrl_q[3], 2) |-> !compare_irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while masked");
   property p_no_flag;
      rs && a == 12'h028 && !duty_q |=> q[3:0] == 4'h0;
   endproperty
   a_no_flag: assert property (p_no_flag) else $error("flag at zero duty");
endmodule
bind pwm_timer pwm_timer_props u_props (
   .pclk, .presetn, .apb_req, .apb_rsp, .modulated_output, .output_drive_en, .compare_irq
);

//--- tb/pwm_stage.sv
module pwm_stage (
   // Clock
   input  wire logic       pclk,
   // From timer and bench
   input  wire logic [3:0] modulated_output,
   input  wire logic [1:0] src_cmd,
   // Break sources
   output logic            break_pin,
   output logic            comparator_out,
   // Measurements over the last ch0 period; overlap is a running count since start
   output logic [7:0]      hi0,
   output logic [7:0]      hi1,
   output logic [7:0]      per0,
   output logic [7:0]      overlap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] c0;
   logic [7:0] c1;
   logic [7:0] p0;
   logic       last;
   initial begin
      {break_pin, comparator_out, hi0, hi1, per0, overlap, c0, c1, p0, last} = '0;
   end
   // Levels move only after an edge, as a real source would
   always @(posedge pclk) begin
      break_pin <= src_cmd[0];
      comparator_out <= src_cmd[1];
      last <= modulated_output[0];
      overlap <= overlap + 8'(&modulated_output[1:0]);
      if (modulated_output[0] & ~last) begin
         per0 <= p0;
         hi0 <= c0;
         hi1 <= c1;
         p0 <= 8'h01;
         c0 <= 8'h01;
         c1 <= 8'(modulated_output[1]);
      end else begin
         p0 <= p0 + 8'h01;
         c0 <= c0 + 8'(modulated_output[0]);
         c1 <= c1 + 8'(modulated_output[1]);
      end
   end
endmodule

//--- tb/dual_autoreload_pwm_timer_tb.sv
module dual_autoreload_pwm_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pwm_timer_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic x;} row_t;
   // Duties stay above reloads, last row is unmapped
   row_t        rows[9] = '{
      '{12'h000, 32'h7, 32'h7, 1'b0}, '{12'h004, 32'hFF0, 32'hFF0, 1'b0},
      '{12'h008, 32'hFE0, 32'hFE0, 1'b0}, '{12'h00C, 32'hFFA, 32'hFFA, 1'b0},
      '{12'h010, 32'hFFC, 32'hFFC, 1'b0}, '{12'h014, 32'hFF4, 32'hFF4, 1'b0},
      '{12'h018, 32'hFF2, 32'hFF2, 1'b0}, '{12'h01C, 32'hF, 32'hF, 1'b0},
      '{12'h040, 32'h1, 32'h0, 1'b1}};
   logic        pclk;
   logic        presetn;
   apb_req_t    req;
   apb_rsp_t    rsp;
   logic        bpin, cmp, irq, err;
   logic [3:0]  mo, oen;
   logic [1:0]  src;
   logic [7:0]  hi0, hi1, per0, ovl, o;
   logic [31:0] rd, h;
   int          n_mismatch = 0;
   int          n_checks = 0;
   pwm_timer u_dut (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .break_pin(bpin),
      .comparator_out(cmp), .modulated_output(mo), .output_drive_en(oen), .compare_irq(irq));
   pwm_stage u_stage (.pclk, .modulated_output(mo), .src_cmd(src), .break_pin(bpin),
      .comparator_out(cmp), .hi0, .hi1, .per0, .overlap(ovl));
   task automatic close_out();
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Request held until pready is seen; data taken at that edge
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int i;
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (rsp.pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         close_out();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      chk(rd, e);
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   initial begin
      presetn = 1'b0;
      req = '0;
      src = 2'b00;
      cyc(20);
      chk(32'(mo), 32'h0);
      chk(32'(oen), 32'hF);
      presetn <= 1'b1;
      apb(12'h02C, 1'b0, 32'h0);
      chk(32'(rd < 32'h28), 32'h1);
      rdc(12'h030, 32'h0);
      rdc(12'h000, 32'h6);
      rdc(12'h028, 32'h0);
      foreach (rows[k]) begin
         wr(rows[k].a, rows[k].d);
         rdc(rows[k].a, rows[k].e);
         chk(32'(err), 32'(rows[k].x));
      end
      cyc(4200);
      apb(12'h030, 1'b0, 32'h0);
      chk(32'(rd >= 32'hFE0 && rd <= 32'hFFF), 32'h1);
      rdc(12'h028, 32'hF);
      wr(12'h000, 32'h6);
      cyc(60);
      h = 32'hB;
      chk(32'(hi0), h);
      chk(32'(per0), 32'h10);
      chk(32'(hi1), h + 32'h2);
      wr(12'h000, 32'hE);
      cyc(20);
      chk(32'(irq), 32'h1);
      wr(12'h000, 32'h6);
      cyc(4);
      chk(32'(irq), 32'h0);
      wr(12'h01C, 32'h1F);
      cyc(60);
      chk(32'(hi0), 32'h10 - h);
      wr(12'h01C, 32'hF);
      wr(12'h000, 32'h0);
      wr(12'h010, 32'hFF8);
      cyc(60);
      chk(32'(hi1), h + 32'h2);
      wr(12'h000, 32'h6);
      cyc(60);
      chk(32'(hi1), h - 32'h2);
      wr(12'h020, 32'h84);
      cyc(60);
      o = ovl;
      cyc(40);
      chk(32'(ovl), 32'(o));
      chk(32'(hi0), h - 32'h4);
      chk(32'(hi1), 32'hC - h);
      wr(12'h020, 32'h80);
      cyc(60);
      chk(32'(mo[1:0]), 32'h0);
      wr(12'h020, 32'h0);
      wr(12'h024, 32'h12D);
      src <= 2'b01;
      cyc(10);
      chk(32'(mo), 32'h5);
      apb(12'h024, 1'b0, 32'h0);
      chk(32'(rd[9]), 32'h1);
      rdc(12'h02C, 32'h0);
      rdc(12'h004, 32'h0);
      src <= 2'b00;
      cyc(4);
      wr(12'h024, 32'h12D);
      cyc(10);
      apb(12'h02C, 1'b0, 32'h0);
      chk(32'(rd != 32'h0), 32'h1);
      wr(12'h024, 32'h12E);
      src <= 2'b10;
      cyc(10);
      apb(12'h024, 1'b0, 32'h0);
      chk(32'(rd[9]), 32'h0);
      wr(12'h024, 32'h12F);
      cyc(10);
      chk(32'(mo), 32'h5);
      src <= 2'b00;
      cyc(4);
      wr(12'h024, 32'h12D);
      cyc(4);
      wr(12'h024, 32'h129);
      cyc(4);
      apb(12'h024, 1'b0, 32'h0);
      chk(32'(rd[9]), 32'h1);
      src <= 2'b01;
      cyc(4);
      wr(12'h024, 32'h128);
      src <= 2'b00;
      cyc(4);
      wr(12'h024, 32'h32C);
      cyc(4);
      apb(12'h02C, 1'b0, 32'h0);
      chk(32'(rd != 32'h0), 32'h1);
      wr(12'h024, 32'h32D);
      cyc(6);
      chk(32'(mo), 32'h5);
      rdc(12'h02C, 32'h0);
      wr(12'h000, 32'h7);
      wr(12'h024, 32'h2AD);
      cyc(6);
      chk(32'(mo[3:2]), 32'h1);
      rdc(12'h030, 32'h0);
      apb(12'h02C, 1'b0, 32'h0);
      chk(32'(rd != 32'h0), 32'h1);
      close_out();
   end
endmodule
